// *** src/rtc_dev.sv ***
// device end: registers, filter calibration, receive and transmit sequencing
`timescale 1ns/1ps
`default_nettype none
module rtc_dev #(
  parameter int unsigned FB_DEPTH = 64,
  parameter int unsigned TX_LEAD_CYCLES = rtc_pkg::TX_LEAD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rtc_link_if.dev link,
  input wire logic rx_start_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  output logic mod_override_o,
  output logic mod_chip_o,
  output logic pll_override_o,
  output logic pll_tx_o,
  output logic [5:0] filter_tune_o,
  output logic cal_active_o,
  output logic [7:0] tx_byte_o,
  output logic tx_byte_valid_o,
  output logic tx_active_o
);
  import rtc_pkg::*;
  localparam int AW = $clog2(FB_DEPTH);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (FB_DEPTH < 2 || FB_DEPTH > 64 || (1 << AW) != FB_DEPTH) begin : g_chk_fb
    $error("buffer depth must be a power of two up to 64");
  end
  if (TX_LEAD_CYCLES < 1 || TX_LEAD_CYCLES > 16383) begin : g_chk_lead
    $error("transmit lead time out of counter range");
  end
  typedef struct packed {
    rtc_rstate_e state;
    logic [7:0] ctrl0;
    logic [1:0] rate;
    logic [7:0] irq_mask;
    logic [7:0] irq_stat;
    logic filt_rsv;
    logic [5:0] tune;
    logic [10:0] cal_cnt;
    logic [7:0] tst;
    logic [FB_DEPTH-1:0][7:0] fb;
    logic [FB_DEPTH-1:0] fb_ok;
    logic rx_on;
    logic [AW:0] rx_cnt;
    logic [13:0] tx_cnt;
    logic [AW:0] tx_idx;
    logic [7:0] tx_byte;
    logic tx_v;
    logic tx_act;
    logic trg1, trg2, trg3;
    logic irq;
    logic mod_ovr, mod_chip, pll_ovr, pll_tx, cal_act;
  } rtc_dev_s;
  rtc_dev_s q, d;
  logic [7:0] spi_cmd, spi_wdata, rd_data, set, clr, eff_tst;
  logic spi_cmd_v, spi_wr_v, start_tx;
  logic [5:0] adr;
  logic [8:0] tx_len;
  // ---------------------------------------------------------------
  // serial access port
  // ---------------------------------------------------------------
  rtc_spi_slave u_spi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sclk_i(link.sclk),
    .mosi_i(link.mosi),
    .cs_n_i(link.cs_n),
    .rd_data_i(rd_data),
    .cmd_o(spi_cmd),
    .cmd_valid_o(spi_cmd_v),
    .wdata_o(spi_wdata),
    .wr_valid_o(spi_wr_v),
    .miso_o(link.miso),
    .miso_oe_o(link.miso_oe)
  );
  // ---------------------------------------------------------------
  // next state of the whole device
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    set = 8'h00;
    clr = 8'h00;
    rd_data = 8'h00;
    start_tx = 1'b0;
    adr = spi_cmd[5:0];
    tx_len = {2'b00, q.fb[0][6:0]} + 9'h001;
    d.trg1 = link.sleep_transmit_trigger_pin;
    d.trg2 = q.trg1;
    d.trg3 = q.trg2;
    d.tx_v = 1'b0;
    // calibration countdown; start bit reads back as busy
    if (q.cal_cnt != 11'h000) begin
      d.cal_cnt = q.cal_cnt - 11'h001;
    end
    // read answer, computed from the command byte just received
    if (spi_cmd[CMD_FB_BIT]) begin
      rd_data = q.fb[adr[AW-1:0]];
    end else begin
      case (adr)
        ADR_STATE: begin
          unique case (q.state)
            RTC_OFF: rd_data = {3'h0, CMD_OFF};
            RTC_SYNTH: rd_data = {3'h0, CMD_SYNTH};
            RTC_LISTEN: rd_data = {3'h0, CMD_LISTEN};
            RTC_TX: rd_data = {3'h0, CMD_TX_START};
          endcase
        end
        ADR_CTRL0: rd_data = q.ctrl0;
        ADR_CTRL2: rd_data = {6'h00, q.rate};
        ADR_IRQ_MASK: rd_data = q.irq_mask;
        ADR_IRQ_STAT: rd_data = q.irq_stat;
        ADR_FILT: rd_data = {q.cal_cnt != 11'h000, q.filt_rsv, q.tune};
        ADR_TST: rd_data = q.tst;
        default: rd_data = 8'h00;
      endcase
    end
    // side effects of a read
    if (spi_cmd_v && !spi_cmd[CMD_WR_BIT]) begin
      if (!spi_cmd[CMD_FB_BIT] && adr == ADR_IRQ_STAT) begin
        clr = 8'hFF;
      end
      // reading ahead of the arriving frame gives stale data
      if (spi_cmd[CMD_FB_BIT] && q.rx_on && {1'b0, adr[AW-1:0]} >= q.rx_cnt) begin
        set[IRQ_UNDERRUN] = 1'b1;
      end
    end
    // receive path into the frame buffer
    if (q.state == RTC_LISTEN) begin
      if (rx_start_i) begin
        set[IRQ_RX_START] = 1'b1;
        d.rx_on = 1'b1;
        d.rx_cnt = '0;
        d.fb_ok = '0;
      end else if (q.rx_on && rx_byte_valid_i && !q.rx_cnt[AW]) begin
        d.fb[q.rx_cnt[AW-1:0]] = rx_byte_i;
        d.fb_ok[q.rx_cnt[AW-1:0]] = 1'b1;
        d.rx_cnt = q.rx_cnt + 1'b1;
      end else if (q.rx_on && rx_end_i) begin
        set[IRQ_FRAME_DONE] = 1'b1;
        d.rx_on = 1'b0;
      end
    end
    // transmit sequencer: lead time, then one byte per byte time
    if (q.state == RTC_TX) begin
      if (q.tx_cnt != 14'h0000) begin
        d.tx_cnt = q.tx_cnt - 14'h0001;
      end else if (q.tx_idx[AW] || {{(8 - AW){1'b0}}, q.tx_idx} >= tx_len) begin
        set[IRQ_FRAME_DONE] = 1'b1;
        d.state = RTC_SYNTH;
        d.fb_ok = '0;
      end else if (!q.fb_ok[q.tx_idx[AW-1:0]]) begin
        // host did not fill the buffer in time
        set[IRQ_UNDERRUN] = 1'b1;
        d.state = RTC_SYNTH;
        d.fb_ok = '0;
      end else begin
        d.tx_byte = q.fb[q.tx_idx[AW-1:0]];
        d.tx_v = 1'b1;
        d.tx_idx = q.tx_idx + 1'b1;
        d.tx_cnt = 14'(BYTE_CYC >> q.rate) - 14'h0001;
      end
    end
    // register and buffer writes
    if (spi_wr_v && spi_cmd[CMD_WR_BIT]) begin
      if (spi_cmd[CMD_FB_BIT]) begin
        d.fb[adr[AW-1:0]] = spi_wdata;
        d.fb_ok[adr[AW-1:0]] = 1'b1;
      end else begin
        case (adr)
          ADR_STATE: begin
            if (spi_wdata[4:0] == CMD_TX_START && q.state == RTC_SYNTH) begin
              start_tx = 1'b1;
            end else if (spi_wdata[4:0] == CMD_OFF) begin
              d.state = RTC_OFF;
              d.rx_on = 1'b0;
            end else if (spi_wdata[4:0] == CMD_SYNTH && q.state != RTC_TX) begin
              d.state = RTC_SYNTH;
              d.rx_on = 1'b0;
            end else if (spi_wdata[4:0] == CMD_LISTEN && q.state != RTC_TX) begin
              d.state = RTC_LISTEN;
            end
          end
          ADR_CTRL0: d.ctrl0 = spi_wdata;
          ADR_CTRL2: d.rate = spi_wdata[1:0];
          ADR_IRQ_MASK: d.irq_mask = spi_wdata;
          ADR_FILT: begin
            d.filt_rsv = spi_wdata[6];
            d.tune = spi_wdata[5:0];
            if (spi_wdata[CAL_START_BIT]) begin
              d.cal_cnt = 11'(CAL_CYC);
            end
          end
          ADR_TST: d.tst = spi_wdata;
          default: d.tst = q.tst;
        endcase
      end
    end
    // trigger pin edge starts a transmission like the command
    if (q.trg2 && !q.trg3 && q.state == RTC_SYNTH) begin
      start_tx = 1'b1;
    end
    if (start_tx) begin
      d.state = RTC_TX;
      d.tx_cnt = 14'(TX_LEAD_CYCLES);
      d.tx_idx = '0;
      d.rx_on = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | set;
    d.irq = |(d.irq_stat & d.irq_mask);
    // test overrides fall back to reset values without the power monitor
    eff_tst = d.ctrl0[CTRL0_PME_BIT] ? d.tst : TST_RST;
    d.mod_ovr = eff_tst[TST_FORCE];
    d.mod_chip = eff_tst[TST_FORCE] & eff_tst[TST_CHIP];
    d.pll_ovr = eff_tst[TST_TXRX_SEL];
    d.pll_tx = eff_tst[TST_TXRX_SEL] ? eff_tst[TST_TXRX] : (d.state == RTC_TX);
    d.cal_act = d.cal_cnt != 11'h000;
    d.tx_act = d.state == RTC_TX;
  end
  // ---------------------------------------------------------------
  // state register; reset enters radio off with calibration running
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.state <= RTC_OFF;
      q.ctrl0 <= CTRL0_RST;
      q.rate <= RATE_RST;
      q.irq_mask <= IRQ_MASK_RST;
      q.filt_rsv <= FILT_RSV_RST;
      q.tune <= TUNE_RST;
      q.cal_cnt <= 11'(CAL_CYC);
      q.cal_act <= 1'b1;
      q.tst <= TST_RST;
    end else begin
      q <= d;
    end
  end
  assign link.irq = q.irq;
  assign mod_override_o = q.mod_ovr;
  assign mod_chip_o = q.mod_chip;
  assign pll_override_o = q.pll_ovr;
  assign pll_tx_o = q.pll_tx;
  assign filter_tune_o = q.tune;
  assign cal_active_o = q.cal_act;
  assign tx_byte_o = q.tx_byte;
  assign tx_byte_valid_o = q.tx_v;
  assign tx_active_o = q.tx_act;
endmodule
`default_nettype wire

// *** src/rtc_host.sv ***
// host end: wishbone registers driving the serial master and the trigger pin
`timescale 1ns/1ps
`default_nettype none
module rtc_host #(
  parameter int unsigned HALF = rtc_pkg::SPI_HALF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  rtc_link_if.host link
);
  import rtc_pkg::*;
  // the device samples our clock, so each half needs several of its cycles
  if (HALF < 8 || HALF > 255) begin : g_chk_half
    $error("serial half period must be 8 to 255 cycles");
  end
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic busy;
    logic cs_n, sclk, mosi, trig;
    logic [7:0] half;
    logic [5:0] edges;
    logic [15:0] tx;
    logic [7:0] rx;
    logic mi1, mi2, irq1, irq2;
  } rtc_host_s;
  rtc_host_s q, d;
  logic req;
  // ---------------------------------------------------------------
  // bus slave and serial master
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    d.ack = req;
    d.mi1 = link.miso_line;
    d.mi2 = q.mi1;
    d.irq1 = link.irq;
    d.irq2 = q.irq1;
    if (req) begin
      case (wb_adr_i)
        WB_STAT: d.dat = {16'h0000, q.rx, 6'h00, q.irq2, q.busy};
        WB_TRIG: d.dat = {31'h0, q.trig};
        default: d.dat = 32'h0000_0000;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == WB_XFER && !q.busy) begin
          d.busy = 1'b1;
          d.cs_n = 1'b0;
          d.tx = wb_dat_i[15:0];
          d.mosi = wb_dat_i[15];
          d.half = 8'(HALF - 1);
          d.edges = 6'h00;
        end else if (wb_adr_i == WB_TRIG) begin
          d.trig = wb_dat_i[0];
        end
      end
    end
    // even edges rise and sample, odd edges fall and shift
    if (q.busy) begin
      if (q.half != 8'h00) begin
        d.half = q.half - 8'h01;
      end else begin
        d.half = 8'(HALF - 1);
        d.edges = q.edges + 6'h01;
        if (q.edges == 6'h21) begin
          d.busy = 1'b0;
        end else if (q.edges == 6'h20) begin
          d.cs_n = 1'b1;
        end else if (!q.edges[0]) begin
          d.sclk = 1'b1;
          d.rx = {q.rx[6:0], q.mi2};
        end else begin
          d.sclk = 1'b0;
          d.tx = {q.tx[14:0], 1'b0};
          d.mosi = q.tx[14];
        end
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign link.sclk = q.sclk;
  assign link.mosi = q.mosi;
  assign link.cs_n = q.cs_n;
  assign link.sleep_transmit_trigger_pin = q.trig;
endmodule
`default_nettype wire

// *** src/rtc_link_if.sv ***
// serial link, trigger pin and interrupt line between host and device
`timescale 1ns/1ps
`default_nettype none
interface rtc_link_if;
  logic sclk;
  logic mosi;
  logic cs_n;
  logic miso;
  logic miso_oe;
  logic sleep_transmit_trigger_pin;
  logic irq;
  // undriven data line reads low
  wire miso_line = miso_oe ? miso : 1'b0;
  modport dev (input sclk, input mosi, input cs_n, input sleep_transmit_trigger_pin,
               output miso, output miso_oe, output irq);
  modport host (output sclk, output mosi, output cs_n, output sleep_transmit_trigger_pin,
                input miso_line, input irq);
endinterface
`default_nettype wire

// *** src/rtc_pkg.sv ***
// constants, state codes and register layout shared by both ends of the radio control link
// Functional notes
// - manual modulation select forces the chip source
// - manual chip value gives constant 0 or 1 chips
// - direction choice 0 receive, 1 transmit frequency
// - direction manual select overrides normal PLL frequency
// - test bits act only with power monitor enabled
// - calibration starts itself on leaving reset
// - host recalibrates at least every five minutes
// - start bit runs calibration, clears when done
// - six-bit tune value, reset 0x18, any value
// - listening raises frame start on detection
// - received frame complete raises frame done
// - relaxed host reads buffer after frame done
// - first byte readable after first byte time
// - reading past received data raises underrun
// - trigger pin or command starts transmission
// - host starts transmit only from synthesizer ready
// - transmission completion raises frame done
// - header generated internally before buffer is needed
// - settle plus header time before first buffer byte
// - buffer not filled in time raises underrun
`default_nettype none
package rtc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CAL_US = 25;
  localparam int unsigned CAL_CYC = CAL_US * CLK_MHZ;
  localparam int unsigned PLL_SETTLE_US = 16;
  localparam int unsigned SHR_US = 160;
  localparam int unsigned TX_LEAD_CYC = (PLL_SETTLE_US + SHR_US) * CLK_MHZ;
  localparam int unsigned BYTE_US = 32;
  localparam int unsigned BYTE_CYC = BYTE_US * CLK_MHZ;
  localparam int unsigned SPI_HALF = 8;
  // ---------------------------------------------------------------
  // serial command byte and device register offsets
  // ---------------------------------------------------------------
  localparam int CMD_WR_BIT = 7;
  localparam int CMD_FB_BIT = 6;
  localparam logic [5:0] ADR_STATE = 6'h02;
  localparam logic [5:0] ADR_CTRL0 = 6'h03;
  localparam logic [5:0] ADR_CTRL2 = 6'h0C;
  localparam logic [5:0] ADR_IRQ_MASK = 6'h0E;
  localparam logic [5:0] ADR_IRQ_STAT = 6'h0F;
  localparam logic [5:0] ADR_FILT = 6'h18;
  localparam logic [5:0] ADR_TST = 6'h3D;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int TST_FORCE = 7;
  localparam int TST_CHIP = 6;
  localparam int TST_TXRX = 5;
  localparam int TST_TXRX_SEL = 4;
  localparam logic [7:0] TST_RST = 8'h00;
  localparam int CAL_START_BIT = 7;
  localparam logic FILT_RSV_RST = 1'b1;
  localparam logic [5:0] TUNE_RST = 6'h18;
  localparam int CTRL0_PME_BIT = 4;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam int IRQ_RX_START = 2;
  localparam int IRQ_FRAME_DONE = 3;
  localparam int IRQ_UNDERRUN = 6;
  // ---------------------------------------------------------------
  // state commands and state codes
  // ---------------------------------------------------------------
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_LISTEN = 5'h06;
  localparam logic [4:0] CMD_OFF = 5'h08;
  localparam logic [4:0] CMD_SYNTH = 5'h09;
  typedef enum logic [3:0] {
    RTC_OFF = 4'b0001,
    RTC_SYNTH = 4'b0010,
    RTC_LISTEN = 4'b0100,
    RTC_TX = 4'b1000
  } rtc_rstate_e;
  // ---------------------------------------------------------------
  // host wishbone register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] WB_XFER = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_TRIG = 8'h08;
endpackage
`default_nettype wire

// *** src/rtc_spi_slave.sv ***
// serial slave: oversampled clock, command byte then data byte
`timescale 1ns/1ps
`default_nettype none
module rtc_spi_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] cmd_o,
  output logic cmd_valid_o,
  output logic [7:0] wdata_o,
  output logic wr_valid_o,
  output logic miso_o,
  output logic miso_oe_o
);
  import rtc_pkg::*;
  typedef struct packed {
    logic sck1, sck2, sck3;
    logic mo1, mo2;
    logic cs1, cs2;
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic cmd_v;
    logic [7:0] wdata;
    logic wr_v;
    logic [7:0] tx;
    logic miso;
    logic oe;
  } rtc_spis_s;
  rtc_spis_s q, d;
  logic rise, fall;
  // ---------------------------------------------------------------
  // mode 0 shifting on the sampled serial clock
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    rise = q.sck2 & ~q.sck3;
    fall = ~q.sck2 & q.sck3;
    d.sck1 = sclk_i;
    d.sck2 = q.sck1;
    d.sck3 = q.sck2;
    d.mo1 = mosi_i;
    d.mo2 = q.mo1;
    d.cs1 = cs_n_i;
    d.cs2 = q.cs1;
    d.cmd_v = 1'b0;
    d.wr_v = 1'b0;
    d.oe = ~q.cs2;
    if (q.cs2) begin
      d.cnt = 5'h00;
      d.miso = 1'b0;
    end else begin
      if (rise) begin
        d.sh = {q.sh[6:0], q.mo2};
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == 5'h07) begin
          d.cmd = {q.sh[6:0], q.mo2};
          d.cmd_v = 1'b1;
        end
        if (q.cnt == 5'h0F) begin
          d.wdata = {q.sh[6:0], q.mo2};
          d.wr_v = 1'b1;
        end
      end
      // answer byte is loaded well before the eighth falling edge
      if (q.cmd_v) begin
        d.tx = rd_data_i;
      end
      if (fall && q.cnt >= 5'h08) begin
        d.miso = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs1 <= 1'b1;
      q.cs2 <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign cmd_o = q.cmd;
  assign cmd_valid_o = q.cmd_v;
  assign wdata_o = q.wdata;
  assign wr_valid_o = q.wr_v;
  assign miso_o = q.miso;
  assign miso_oe_o = q.oe;
endmodule
`default_nettype wire

// *** testbench/rtc_link_monitor.sv ***
// checker on the serial link wires between host and device
`timescale 1ns/1ps
`default_nettype none
module rtc_link_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic sleep_transmit_trigger_pin,
  input wire logic irq
);
  logic sclk_q;
  logic cs_q;
  logic [4:0] rise_q;
  // count clock rises within one frame, cleared once deselect is seen twice
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      rise_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      if (!cs_n && sclk && !sclk_q) begin
        rise_q <= rise_q + 5'h01;
      end else if (cs_n && cs_q) begin
        rise_q <= 5'h00;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -------------------------------------------------------------
  // framing and drive rules
  // -------------------------------------------------------------
  a_frame_sixteen_bits: assert property ($rose(cs_n) |-> rise_q == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_first_half_low: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("serial clock rose too soon after select");
  a_mosi_hold_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_moves_low: assert property (miso_oe && $past(miso_oe) && !$stable(miso) |-> !sclk)
    else $error("device data moved while clock high");
  a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:5] miso_oe)
    else $error("device did not drive after select");
  a_oe_off_deselect: assert property ($rose(cs_n) |-> ##[1:5] !miso_oe)
    else $error("device kept driving after deselect");
  a_oe_idle_off: assert property (cs_n [*6] |-> !miso_oe)
    else $error("device drives while idle");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench: host and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rtc_pkg::*;
  localparam int unsigned LEAD = 2000;
  localparam logic [7:0] TV [5] = '{8'hF0, 8'h80, 8'hC0, 8'h50, 8'h30};
  logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_rd;
  logic rx_start, rx_bv, rx_end, m_ovr, m_chip, p_ovr, p_tx, cal_active, tx_bv, tx_active;
  logic [7:0] rx_byte, tx_byte;
  logic [5:0] tune;
  int fails, compares;
  rtc_link_if link ();
  rtc_host i_rtc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hF),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .link(link));
  rtc_dev #(.FB_DEPTH(64), .TX_LEAD_CYCLES(LEAD)) i_rtc_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .rx_start_i(rx_start), .rx_byte_valid_i(rx_bv), .rx_byte_i(rx_byte), .rx_end_i(rx_end),
    .mod_override_o(m_ovr), .mod_chip_o(m_chip), .pll_override_o(p_ovr), .pll_tx_o(p_tx),
    .filter_tune_o(tune), .cal_active_o(cal_active), .tx_byte_o(tx_byte), .tx_byte_valid_o(tx_bv),
    .tx_active_o(tx_active));
  rtc_link_monitor i_rtc_link_monitor (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk), .mosi(link.mosi),
    .cs_n(link.cs_n), .miso(link.miso), .miso_oe(link.miso_oe),
    .sleep_transmit_trigger_pin(link.sleep_transmit_trigger_pin), .irq(link.irq));
  // -------------------------------------------------------------
  // report, compare and bus tasks
  // -------------------------------------------------------------
  task automatic tally_and_finish;
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic give_up;
    fails++;
    tally_and_finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold the request until ack is sampled high, then release
  task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_adr <= adr;
    wb_we <= we;
    wb_dat <= dat;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) give_up;
    rd = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  // one serial transfer, polled until the host reports idle
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
    logic [31:0] r;
    int n;
    wb(WB_XFER, 1'b1, {16'h0000, cmd, dat}, r);
    n = 0;
    do begin
      wb(WB_STAT, 1'b0, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    if (r[0] !== 1'b0) give_up;
    rd = r[15:8];
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({2'b10, a}, d, x);
  endtask
  task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
    xfer({2'b00, a}, 8'h00, d);
  endtask
  function automatic logic hit(input int which);
    case (which)
      0: return cal_active === 1'b0;
      1: return link.irq === 1'b1;
      default: return tx_bv === 1'b1;
    endcase
  endfunction
  // bounded wait on a device flag; n is the number of edges it took
  task automatic wait_on(input int which, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!hit(which) && n < 20000);
    if (!hit(which)) give_up;
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    logic [31:0] r;
    int n;
    chk({7'h00, cal_active}, 8'h01);
    reg_rd(ADR_FILT, d);
    chk(d, 8'hD8);
    reg_rd(ADR_TST, d);
    chk(d, TST_RST);
    reg_rd(6'h3F, d);
    chk(d, 8'h00);
    wb(8'h0C, 1'b0, 32'h0, r);
    chk(r[7:0], 8'h00);
    wait_on(0, n);
    reg_rd(ADR_FILT, d);
    chk(d, 8'h58);
    chk({2'b00, tune}, {2'b00, TUNE_RST});
  endtask
  task automatic t_cal;
    logic [7:0] d;
    int n;
    reg_wr(ADR_FILT, 8'hBF);
    reg_rd(ADR_FILT, d);
    chk(d, 8'hBF);
    wait_on(0, n);
    reg_rd(ADR_FILT, d);
    chk(d, 8'h3F);
    chk({2'b00, tune}, 8'h3F);
    reg_wr(ADR_FILT, 8'h00);
    chk({2'b00, tune}, 8'h00);
  endtask
  // first value with the power monitor off must have no effect
  task automatic t_test;
    logic [7:0] d, v, e;
    for (int i = 0; i < 5; i++) begin
      if (i == 1) reg_wr(ADR_CTRL0, 8'h10);
      v = TV[i];
      reg_wr(ADR_TST, v);
      reg_rd(ADR_TST, d);
      chk(d, v);
      e = (i == 0) ? 8'h00 : {4'h0, v[7], v[7] & v[6], v[4], v[4] & v[5]};
      chk({4'h0, m_ovr, m_chip, p_ovr, p_tx}, e);
    end
    reg_wr(ADR_TST, 8'h00);
    reg_wr(ADR_CTRL0, 8'h00);
  endtask
  task automatic t_rx;
    logic [7:0] d;
    int n;
    reg_wr(ADR_IRQ_MASK, 8'h4C);
    reg_wr(ADR_STATE, {3'b000, CMD_LISTEN});
    @(posedge clk_i);
    rx_start <= 1'b1;
    @(posedge clk_i);
    rx_start <= 1'b0;
    wait_on(1, n);
    reg_rd(ADR_IRQ_STAT, d);
    chk(d, 8'h04);
    xfer(8'h40, 8'h00, d);
    reg_rd(ADR_IRQ_STAT, d);
    chk(d, 8'h40);
    @(posedge clk_i);
    rx_byte <= 8'hA5;
    rx_bv <= 1'b1;
    @(posedge clk_i);
    rx_bv <= 1'b0;
    xfer(8'h40, 8'h00, d);
    chk(d, 8'hA5);
    @(posedge clk_i);
    rx_end <= 1'b1;
    @(posedge clk_i);
    rx_end <= 1'b0;
    wait_on(1, n);
    reg_rd(ADR_IRQ_STAT, d);
    chk(d, 8'h08);
    chk({7'h00, link.irq}, 8'h00);
  endtask
  // pin-started frame of two bytes, then a command start with nothing loaded
  task automatic t_tx;
    logic [7:0] d;
    logic [31:0] r;
    int n;
    reg_wr(ADR_STATE, {3'b000, CMD_SYNTH});
    xfer(8'hC0, 8'h01, d);
    xfer(8'hC1, 8'h5A, d);
    wb(WB_TRIG, 1'b1, 32'h1, r);
    wait_on(2, n);
    chk(tx_byte, 8'h01);
    chk({7'h00, n >= LEAD && n <= LEAD + 12}, 8'h01);
    chk({7'h00, tx_active}, 8'h01);
    chk({7'h00, p_tx}, 8'h01);
    wait_on(2, n);
    chk(tx_byte, 8'h5A);
    chk({7'h00, n == 1600}, 8'h01);
    wait_on(1, n);
    reg_rd(ADR_IRQ_STAT, d);
    chk(d, 8'h08);
    wb(WB_TRIG, 1'b1, 32'h0, r);
    reg_wr(ADR_STATE, {3'b000, CMD_TX_START});
    wait_on(1, n);
    reg_rd(ADR_IRQ_STAT, d);
    chk(d, 8'h40);
    reg_rd(ADR_STATE, d);
    chk(d, {3'b000, CMD_SYNTH});
    chk({7'h00, tx_active}, 8'h00);
    reg_wr(ADR_STATE, {3'b000, CMD_OFF});
    reg_rd(ADR_STATE, d);
    chk(d, {3'b000, CMD_OFF});
  endtask
  // clock source
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // reset, then the scenarios in order
  initial begin
    rst_i = 1'b1;
    {wb_we, wb_cyc, wb_stb, rx_start, rx_bv, rx_end} = 6'h00;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    rx_byte = 8'h00;
    fails = 0;
    compares = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_cal;
    t_test;
    t_rx;
    t_tx;
    tally_and_finish;
  end
endmodule
`default_nettype wire
